// [rtl/bbs_consts.vh]
`ifndef BBS_CONSTS_VH
`define BBS_CONSTS_VH
// Clock period in ns
`define BBS_CLK_NS          10
// Memory geometry
`define BBS_ADDR_W          13
`define BBS_DATA_W          8
`define BBS_DEPTH           8192
// Read timing, ns
`define BBS_ADDR_ACCESS_NS  100
`define BBS_CS_ACCESS_NS    100
`define BBS_OE_ACCESS_NS    50
`define BBS_OUT_HOLD_NS     5
`define BBS_CYCLE_NS        100
// Write timing, ns
`define BBS_STROBE_LOW_NS   80
`define BBS_DATA_SETUP_NS   50
`define BBS_DATA_HOLD_NS    5
`define BBS_ADDR_HOLD_NS    10
`define BBS_STROBE_HIZ_NS   50
// Recovery after power-up, ns
`define BBS_RECOVERY_NS     1000000
// Derived cycle counts, least times rounded up
`define BBS_CYC_UP(ns)      (((ns) + `BBS_CLK_NS - 1) / `BBS_CLK_NS)
`define BBS_READ_CYC        `BBS_CYC_UP(`BBS_ADDR_ACCESS_NS)
`define BBS_CYCLE_CYC       `BBS_CYC_UP(`BBS_CYCLE_NS)
`define BBS_STROBE_CYC      `BBS_CYC_UP(`BBS_STROBE_LOW_NS)
`define BBS_SETUP_CYC       `BBS_CYC_UP(`BBS_DATA_SETUP_NS)
`define BBS_HOLD_CYC        `BBS_CYC_UP(`BBS_ADDR_HOLD_NS)
`define BBS_HIZ_CYC         `BBS_CYC_UP(`BBS_STROBE_HIZ_NS)
`define BBS_RECOVERY_CYC    `BBS_CYC_UP(`BBS_RECOVERY_NS)
`endif

// [rtl/bbs_sync2.v]
`timescale 1ns/1ps
module bbs_sync2 #(
	parameter W = 8
) (
	// Clock and reset
	input  wire         core_clk,
	input  wire         rst,
	// Async input and synced output
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);
	reg [W-1:0] meta_reg;

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			meta_reg <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end
		else
		begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule // bbs_sync2

// [rtl/bbs_host.v]
// Operation
// (R1) Read mode: write strobe high, chip select low.
// (R2) Thirteen address lines pick one of 8192 bytes.
// (R3) Read data valid after address access time, bounded by select/enable times.
// (R4) Memory drives data only while select and output enable are low.
// (R5) Early-enabled outputs are indeterminate until address access completes.
// (R6) On address change old data holds briefly, then indeterminate.
// (R7) Write mode: write strobe and chip select both low.
// (R8) Write starts at the later falling edge of strobe or select.
// (R9) Write ends at the earlier rising edge, storing present byte.
// (R10) Host keeps address stable across the whole write.
// (R11) Host holds select or strobe high before the next cycle.
// (R12) Host keeps data valid setup before and hold after write end.
// (R13) Host keeps output enable high during writes.
// (R14) Strobe falling with outputs on releases data lines shortly after.
// (R15) Power-fail deselects memory, blocks writes, ignores inputs.
// (R16) Power failure mid-write may corrupt only the addressed byte.
// (R17) After power-up, accesses wait recovery time past upper threshold.
// (R18) Host holds chip select high while supply rises.
// (R19) Address and select access at most 100 ns; cycle at least 100 ns.
// (R20) Output enable to valid data at most 50 ns.
// (R21) Write strobe held low at least 80 ns.
// (R22) Write data valid at least 50 ns before strobe rises.
// (R23) Power-fail is one discrete input forcing deselect and protection.
`timescale 1ns/1ps
`include "bbs_consts.vh"
module bbs_host #(
	parameter RECOVERY_CYC = `BBS_RECOVERY_CYC
) (
	// Clock and reset
	input  wire        core_clk,
	input  wire        rst,
	// User request port
	input  wire        req_valid,
	input  wire        req_write,
	input  wire [12:0] req_addr,
	input  wire [7:0]  req_wdata,
	output wire        req_ready,
	output reg  [7:0]  rsp_rdata,
	output reg         rsp_valid,
	// Supply monitor
	input  wire        power_fail,
	output wire        mem_ready,
	// Memory pins
	output reg  [12:0] addr_lines,
	output reg         cs_n,
	output reg         oe_n,
	output reg         we_n,
	input  wire [7:0]  data_io_in,
	output reg  [7:0]  data_io_out,
	output reg         data_io_oe
);
	// One-hot controller states
	localparam [5:0] ST_BOOT  = 6'h01;
	localparam [5:0] ST_IDLE  = 6'h02;
	localparam [5:0] ST_READ  = 6'h04;
	localparam [5:0] ST_WRITE = 6'h08;
	localparam [5:0] ST_HOLD  = 6'h10;
	localparam [5:0] ST_GAP   = 6'h20;

	// Phase lengths in clock cycles
	localparam [19:0] READ_CYC   = `BBS_READ_CYC;
	localparam [19:0] STROBE_CYC = `BBS_STROBE_CYC;
	localparam [19:0] SETUP_CYC  = `BBS_SETUP_CYC;
	localparam [19:0] HOLD_CYC   = `BBS_HOLD_CYC;
	localparam [19:0] CYCLE_CYC  = `BBS_CYCLE_CYC;
	localparam [19:0] REC_CYC    = RECOVERY_CYC;

	wire [7:0] data_sync;
	wire       fail_sync;
	reg  [5:0]  state_reg;
	reg  [19:0] cnt_reg;

	// Read data and power-fail flag cross into the clock domain
	bbs_sync2 #(.W(9)) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.async_in ({power_fail, data_io_in}),
		.sync_out ({fail_sync, data_sync})
	);

	function [19:0] at_least;
		input [19:0] a;
		input [19:0] b;
		at_least = (a > b) ? a : b;
	endfunction

	// Last count of each phase; reads wait out both sync stages
	localparam [19:0] READ_LAST  = at_least(READ_CYC, CYCLE_CYC) + 20'h00002;
	localparam [19:0] WRITE_LAST = at_least(STROBE_CYC, SETUP_CYC) - 20'h00001;
	localparam [19:0] HOLD_LAST  = HOLD_CYC - 20'h00001;
	localparam [19:0] BOOT_LAST  = REC_CYC - 20'h00001;

	// Requests refused while busy, booting or failing
	assign req_ready = (state_reg == ST_IDLE) && !fail_sync;
	assign mem_ready = (state_reg != ST_BOOT);

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			state_reg   <= ST_BOOT;
			cnt_reg     <= 20'h00000;
			addr_lines  <= 13'h0000;
			cs_n        <= 1'b1;
			oe_n        <= 1'b1;
			we_n        <= 1'b1;
			data_io_out <= 8'h00;
			data_io_oe  <= 1'b0;
			rsp_rdata   <= 8'h00;
			rsp_valid   <= 1'b0;
		end
		else
		begin
			rsp_valid <= 1'b0;
			if (fail_sync)
			begin
				// Deselect and idle the bus during supply failure
				state_reg  <= ST_BOOT; // (R15)
				cnt_reg    <= 20'h00000; // (R23)
				cs_n       <= 1'b1; // (R18)
				oe_n       <= 1'b1;
				we_n       <= 1'b1;
				data_io_oe <= 1'b0;
			end
			else
			begin
				case (state_reg)
				ST_BOOT:
				begin
					cs_n <= 1'b1; // (R18)
					if (cnt_reg >= BOOT_LAST)
					begin
						state_reg <= ST_IDLE; // (R17)
						cnt_reg   <= 20'h00000;
					end
					else
						cnt_reg <= cnt_reg + 20'h00001;
				end
				ST_IDLE:
				begin
					cnt_reg <= 20'h00000;
					if (req_valid)
					begin
						addr_lines <= req_addr; // (R2)
						cs_n       <= 1'b0;
						if (req_write)
						begin
							we_n        <= 1'b0; // (R7)
							oe_n        <= 1'b1; // (R13)
							data_io_out <= req_wdata;
							data_io_oe  <= 1'b1;
							state_reg   <= ST_WRITE; // (R8)
						end
						else
						begin
							we_n      <= 1'b1; // (R1)
							oe_n      <= 1'b0; // (R4)
							state_reg <= ST_READ;
						end
					end
				end
				ST_READ:
				begin
					// Sample after access time plus two sync stages
					if (cnt_reg >= READ_LAST)
					begin
						rsp_rdata <= data_sync; // (R3) (R5) (R19) (R20)
						rsp_valid <= 1'b1;
						cs_n      <= 1'b1;
						oe_n      <= 1'b1; // (R6)
						cnt_reg   <= 20'h00000;
						state_reg <= ST_GAP;
					end
					else
						cnt_reg <= cnt_reg + 20'h00001;
				end
				ST_WRITE:
				begin
					// Strobe low long enough for width and data setup
					if (cnt_reg >= WRITE_LAST)
					begin
						we_n      <= 1'b1; // (R9) (R21) (R22)
						cnt_reg   <= 20'h00000;
						state_reg <= ST_HOLD;
					end
					else
						cnt_reg <= cnt_reg + 20'h00001;
				end
				ST_HOLD:
				begin
					// Address and data kept past strobe rise
					if (cnt_reg >= HOLD_LAST)
					begin
						cs_n       <= 1'b1; // (R10) (R11) (R12)
						data_io_oe <= 1'b0;
						cnt_reg    <= 20'h00000;
						state_reg  <= ST_GAP;
					end
					else
						cnt_reg <= cnt_reg + 20'h00001;
				end
				ST_GAP:
				begin
					// Deselected recovery before next cycle
					if (cnt_reg >= HOLD_LAST)
					begin
						cnt_reg   <= 20'h00000;
						state_reg <= ST_IDLE; // (R11)
					end
					else
						cnt_reg <= cnt_reg + 20'h00001;
				end
				default:
				begin
					state_reg <= ST_BOOT;
					cnt_reg   <= 20'h00000;
				end
				endcase
			end
		end
	end
endmodule // bbs_host

// [test/bbs_host_asserts.sv]
`timescale 1ns/1ps
module bbs_host_chk (
	// Clock, reset, status
	input wire        core_clk,
	input wire        rst,
	input wire        mem_ready,
	input wire        rsp_valid,
	// Memory pins
	input wire [12:0] addr_lines,
	input wire        cs_n,
	input wire        oe_n,
	input wire        we_n,
	input wire [7:0]  data_io_out,
	input wire        data_io_oe
);
	logic power_fail_q;
	assign power_fail_q = !mem_ready;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_addr_write_stable: assert property ((!we_n ##1 !we_n) |-> $stable(addr_lines))
		else $error("address moved during write");
	a_data_write_stable: assert property ((!we_n ##1 !we_n) |-> data_io_oe && $stable(data_io_out))
		else $error("write data not held");
	a_data_after_strobe: assert property (disable iff (rst || power_fail_q) $rose(we_n) |-> data_io_oe && $stable(data_io_out))
		else $error("write data hold missed");
	a_strobe_width: assert property (disable iff (rst || power_fail_q) $fell(we_n) |-> !we_n[*8])
		else $error("strobe too short");
	a_oe_off_write: assert property ((!we_n || data_io_oe) |-> oe_n)
		else $error("output enable low while driving");
	a_addr_hold_cs: assert property ($rose(cs_n) |-> $stable(addr_lines) ##1 cs_n)
		else $error("no hold or gap after cycle");
	a_read_length: assert property ($fell(oe_n) |-> (!cs_n && we_n)[*8])
		else $error("read cycle too short");
	a_read_answer: assert property (($rose(cs_n) && !$past(oe_n) && mem_ready) |-> rsp_valid ##1 !rsp_valid)
		else $error("read end without one answer");
	a_boot_idle: assert property ((!mem_ready ##1 !mem_ready) |-> cs_n && we_n)
		else $error("select during boot");
endmodule // bbs_host_chk
bind bbs_host bbs_host_chk u_chk (.core_clk(core_clk), .rst(rst), .mem_ready(mem_ready),
	.rsp_valid(rsp_valid), .addr_lines(addr_lines), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
	.data_io_out(data_io_out), .data_io_oe(data_io_oe));

// [test/bbs_mem_model.sv]
`timescale 1ns/1ps
module bbs_mem_model (
	// Memory pins
	input wire [12:0]  addr_lines,
	input wire         cs_n,
	input wire         oe_n,
	input wire         we_n,
	input wire         power_fail,
	input wire [7:0]   din,
	output logic [7:0] dout = 8'hA5
);
	logic [7:0] mem [0:8191];
	wire wr = !we_n && !cs_n && !power_fail;
	wire rd = !cs_n && !oe_n && we_n && !power_fail;
	always @(negedge wr)
		if (!power_fail)
			mem[addr_lines] = din;
	// Garbage after any change, valid after access time
	always @(addr_lines, rd)
	begin
		dout <= #5 ~dout;
		if (rd)
			dout <= #100 mem[addr_lines];
	end
endmodule // bbs_mem_model

// [test/battery_backed_sram_port_test.sv]
`timescale 1ns/1ps
module battery_backed_sram_port_test;
	logic        core_clk = 0;
	logic        rst = 1;
	logic        req_valid = 0;
	logic        req_write = 0;
	logic        power_fail = 0;
	logic [12:0] req_addr = 0;
	logic [7:0]  req_wdata = 0;
	wire         req_ready, rsp_valid, mem_ready, cs_n, oe_n, we_n, data_io_oe;
	wire [7:0]   rsp_rdata, data_io_out, mem_q;
	wire [12:0]  addr_lines;
	int          num_errors = 0;
	int          n_tests = 0;
	int          i;
	logic [7:0]  ref_mem [int];
	always #5 core_clk = ~core_clk;
	bbs_host #(.RECOVERY_CYC(20)) dut (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
		.rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid), .power_fail(power_fail),
		.mem_ready(mem_ready), .addr_lines(addr_lines), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
		.data_io_in(data_io_oe ? data_io_out : mem_q), .data_io_out(data_io_out),
		.data_io_oe(data_io_oe));
	bbs_mem_model mem (.addr_lines(addr_lines), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
		.power_fail(power_fail), .din(data_io_out), .dout(mem_q));
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask
	task end_of_test;
		if (num_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task access(input logic wr, input logic [12:0] a, input logic [7:0] d);
		int k;
		@(negedge core_clk);
		req_valid = 1;
		req_write = wr;
		req_addr = a;
		req_wdata = d;
		for (k = 0; k < 200 && req_ready !== 1'b1; k++)
			@(negedge core_clk);
		@(negedge core_clk);
		req_valid = 0;
		if (wr)
			ref_mem[a] = d;
		else
		begin
			for (k = 0; k < 30 && rsp_valid !== 1'b1; k++)
				@(negedge core_clk);
			chk("read_latency", 8'd13, 8'(k));
			chk("read_data", ref_mem[a], rsp_rdata);
		end
	endtask
	initial
	begin
		#100000;
		num_errors++;
		end_of_test;
	end
	initial
	begin
		i = $urandom(32'h3B8F70C9);
		repeat (5) @(negedge core_clk);
		rst = 0;
		access(1, 13'h0000, 8'hFF);
		access(1, 13'h1FFF, 8'h00);
		repeat (24)
			access(1, 13'($urandom), 8'($urandom));
		foreach (ref_mem[a])
			access(0, a[12:0], 8'h00);
		// Supply fails in mid-write
		fork
			access(1, 13'h0001, 8'h3C);
			begin
				repeat (4) @(negedge core_clk);
				power_fail = 1;
			end
		join
		ref_mem.delete(1);
		repeat (8) @(negedge core_clk);
		chk("fail_state", 8'h01, {req_ready, mem_ready, cs_n});
		power_fail = 0;
		for (i = 0; i < 100 && mem_ready !== 1'b1; i++)
			@(negedge core_clk);
		chk("recovery", 8'h01, 8'(i >= 20 && i < 30));
		foreach (ref_mem[a])
			access(0, a[12:0], 8'h00);
		end_of_test;
	end
endmodule // battery_backed_sram_port_test
